/* bench/sdl_link_monitor.sv */
`timescale 1ns/1ps
// ==========
// Checks on the host-driven link wires.
module sdl_link_monitor (
  input wire logic sys_clk_in, // Clock.
  input wire logic reset_in, // Reset.
  input wire logic shift_clk, // Link clock.
  input wire logic serial_data_input, // Link data.
  input wire logic frame_sel_n, // Frame select.
  input wire logic latch_load_n // Load line.
);
  logic clk_q;
  logic [4:0] falls;
  // Counts falling link clock edges within a frame.
  always_ff @(posedge sys_clk_in) begin
    clk_q <= shift_clk;
    if (reset_in || frame_sel_n) falls <= 5'h00;
    else if (clk_q && !shift_clk) falls <= falls + 5'h01;
  end
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  idle_clock_a: assert property (frame_sel_n |-> !shift_clk) else $error("clock outside frame");
  data_hold_a: assert property ($fell(shift_clk) |-> $stable(serial_data_input)) else $error("data moved");
  clock_half_a: assert property ($rose(shift_clk) |-> shift_clk [*4] ##1 !shift_clk) else $error("half");
  word_len_a: assert property ($rose(frame_sel_n) |-> falls == 5'h10) else $error("word length");
  bit_cap_a: assert property (!frame_sel_n && clk_q && !shift_clk |-> falls < 5'h10) else $error("extra");
  first_edge_a: assert property ($fell(frame_sel_n) |-> ##[1:12] $rose(shift_clk)) else $error("no clock");
  load_late_a: assert property ($fell(latch_load_n) |-> frame_sel_n || $fell(frame_sel_n)) else $error("early");
  load_width_a: assert property ($fell(latch_load_n) && frame_sel_n |-> !latch_load_n [*4] ##1 latch_load_n)
    else $error("load pulse width");
  mode_hold_a: assert property (!frame_sel_n && !$past(frame_sel_n) |-> $stable(latch_load_n))
    else $error("mode line moved");
  cover property ($fell(latch_load_n) && frame_sel_n);
  cover property ($rose(frame_sel_n) && !latch_load_n);
  cover property ($rose(frame_sel_n));
endmodule // sdl_link_monitor

/* bench/tb_serial_dac_word_loader.sv */
`timescale 1ns/1ps
// ==========
// Bench: host and device on one link, a second device on a hand-driven link.
module tb_serial_dac_word_loader;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  logic send_in = 1'b0;
  logic [11:0] value_in = 12'h000;
  logic offset_bin_in = 1'b0;
  logic auto_in = 1'b0;
  logic busy_out, done_out, upd, auto_out, auto_b;
  logic signed [11:0] dac, dac_b;
  int err_count = 0;
  int checks = 0;
  int upd_cnt = 0;
  sdl_link_if link_if ();
  sdl_link_if bad_if ();
  sdl_host sdl_host_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link_if.host), .send_in(send_in),
    .value_in(value_in), .offset_bin_in(offset_bin_in), .auto_in(auto_in), .busy_out(busy_out), .done_out(done_out));
  sdl_device sdl_device_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(link_if.dev), .dac_value_out(dac),
    .dac_update_out(upd), .auto_mode_out(auto_out));
  sdl_device sdl_device_bad_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .link(bad_if.dev),
    .dac_value_out(dac_b), .dac_update_out(), .auto_mode_out(auto_b));
  sdl_link_monitor sdl_link_monitor_i (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .shift_clk(link_if.shift_clk),
    .serial_data_input(link_if.serial_data_input), .frame_sel_n(link_if.frame_sel_n),
    .latch_load_n(link_if.latch_load_n));
  // Clock and latch update counter.
  always #25 sys_clk_in = ~sys_clk_in;
  always @(posedge sys_clk_in) if (upd === 1'b1) upd_cnt++;
  // Hand-driven link idles with select high and load low.
  initial begin
    bad_if.shift_clk = 1'b0;
    bad_if.serial_data_input = 1'b0;
    bad_if.frame_sel_n = 1'b1;
    bad_if.latch_load_n = 1'b0;
  end
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic test_done;
    if (err_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic send_word(input logic [11:0] v, input logic ofs, input logic au, input logic [11:0] exp);
    int n;
    n = upd_cnt;
    @(posedge sys_clk_in);
    send_in <= 1'b1;
    value_in <= v;
    offset_bin_in <= ofs;
    auto_in <= au;
    @(posedge sys_clk_in);
    send_in <= 1'b0;
    #1;
    chk("busy", {15'h0000, busy_out}, 16'h0001);
    for (int i = 0; i < 400 && done_out !== 1'b1; i++) @(posedge sys_clk_in) #1;
    chk("done", {15'h0000, done_out}, 16'h0001);
    chk("idle", {15'h0000, busy_out}, 16'h0000);
    repeat (12) @(posedge sys_clk_in);
    chk("dac", {4'h0, dac}, {4'h0, exp});
    chk("mode", {15'h0000, auto_out}, {15'h0000, au});
    chk("updates", 16'(upd_cnt - n), 16'h0001);
  endtask
  // Drives n bits MSB first at a 400 ns link clock, with or without select.
  task automatic bad_frame(input logic [19:0] bits, input int n, input logic frame);
    @(posedge sys_clk_in);
    bad_if.frame_sel_n <= !frame;
    repeat (4) @(posedge sys_clk_in);
    for (int i = n - 1; i >= 0; i--) begin
      bad_if.serial_data_input <= bits[i];
      bad_if.shift_clk <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      bad_if.shift_clk <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
    end
    bad_if.frame_sel_n <= 1'b1;
    repeat (8) @(posedge sys_clk_in);
  endtask
  task automatic bad_link;
    bad_frame(20'hfa5cf, 20, 1'b1);
    chk("overrun", {4'h0, dac_b}, 16'h0a5c);
    chk("auto", {15'h0000, auto_b}, 16'h0001);
    bad_frame(20'h00012, 8, 1'b1);
    chk("partial", {4'h0, dac_b}, 16'h0a5c);
    bad_frame(20'h00123, 16, 1'b0);
    chk("deselected", {4'h0, dac_b}, 16'h0a5c);
  endtask
  // Load-pulse mode on the hand-driven link: word waits, pulse latches, partial word never latches.
  task automatic bad_load;
    bad_if.latch_load_n <= 1'b1;
    bad_frame(20'h01abc, 16, 1'b1);
    chk("mode load", {15'h0000, auto_b}, 16'h0000);
    chk("held", {4'h0, dac_b}, 16'h0a5c);
    bad_if.latch_load_n <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    chk("loaded", {4'h0, dac_b}, 16'h0abc);
    bad_if.latch_load_n <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
    bad_frame(20'h00055, 8, 1'b1);
    bad_if.latch_load_n <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    chk("short load", {4'h0, dac_b}, 16'h0abc);
    bad_if.latch_load_n <= 1'b1;
    repeat (4) @(posedge sys_clk_in);
  endtask
  // Watchdog.
  initial begin
    repeat (20000) @(posedge sys_clk_in);
    err_count++;
    test_done;
  end
  // Main sequence.
  initial begin
    repeat (6) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    repeat (3) @(posedge sys_clk_in);
    send_word(12'h7ff, 1'b0, 1'b1, 12'h7ff);
    send_word(12'h800, 1'b0, 1'b1, 12'h800);
    send_word(12'hfff, 1'b0, 1'b1, 12'hfff);
    send_word(12'h000, 1'b1, 1'b1, 12'h800);
    send_word(12'h5a3, 1'b0, 1'b0, 12'h5a3);
    send_word(12'h0c1, 1'b1, 1'b0, 12'h8c1);
    bad_link;
    bad_load;
    test_done;
  end
endmodule // tb_serial_dac_word_loader

/* common/sdl_defs.svh */
`ifndef SDL_DEFS_SVH
`define SDL_DEFS_SVH
// Word and field layout of one serial frame.
`define SDL_WORD_BITS 16
`define SDL_DATA_BITS 12
`define SDL_CNT_BITS 5
`define SDL_CNT_FULL 5'h10
`define SDL_BYTE_BITS 8
`define SDL_MSB_BIT 11
// Host link clock divider: half period in system clocks.
`define SDL_HALF_DIV 4'h4
`define SDL_DIV_BITS 4
// Host load pulse width in system clocks.
`define SDL_LOAD_PULSE 4'h4
`endif

/* common/sdl_link_if.sv */
`timescale 1ns/1ps
// Three-wire link plus optional latch load line, all driven by the host.
interface sdl_link_if;
  logic shift_clk;
  logic serial_data_input;
  logic frame_sel_n;
  logic latch_load_n;
  modport host (output shift_clk, output serial_data_input, output frame_sel_n, output latch_load_n);
  modport dev (input shift_clk, input serial_data_input, input frame_sel_n, input latch_load_n);
endinterface

/* common/sdl_pkg.sv */
package sdl_pkg;
  // Host transfer states.
  typedef enum logic [4:0] {
    SDL_IDLE = 5'h01,
    SDL_SHIFT = 5'h02,
    SDL_END = 5'h04,
    SDL_LOAD = 5'h08,
    SDL_GAP = 5'h10
  } sdl_host_state_t;
endpackage

/* rtl/sdl_device.sv */
`timescale 1ns/1ps
`include "sdl_defs.svh"
// Behaviour
// - Latched 12 bits are two's complement value.
// - Offset binary hosts invert MSB first.
// - Sixteen-bit words, sampled on falling clock.
// - Three host lines plus optional load.
// - Load low: update on 16th fall.
// - Otherwise host pulses load low after word.
// - Host frames word with select low.
// - Active-high framing pulses get inverted.
// - Byte hosts hold select across bytes.
// - LSB-first hosts reorder, LSB sent last.
// - SPI hosts use polarity 0, phase 1.
// - Drop first four bits, latch last twelve.
// - Counter accepts only sixteen bits per frame.
// - Sample load at frame start to pick mode.
// - Load pulse only after transfer, high before next.
module sdl_device
  import sdl_pkg::*;
(
  input wire logic sys_clk_in, // System clock.
  input wire logic reset_in, // Synchronous reset, active high.
  sdl_link_if.dev link, // Serial link from the host.
  output logic signed [`SDL_DATA_BITS-1:0] dac_value_out, // Output latch, two's complement.
  output logic dac_update_out, // One-cycle pulse when latch is written.
  output logic auto_mode_out // Mode chosen at frame start.
);
  // ==========================================================
  // Input synchronisers
  logic [1:0] clk_sync, data_sync, sel_sync, load_sync;
  logic clk_prev, sel_prev, load_prev;
  // Two flops per pin before any logic reads them; only the three host lines and load are watched.
  always_ff @(posedge sys_clk_in) begin
    clk_sync <= {clk_sync[0], link.shift_clk};
    data_sync <= {data_sync[0], link.serial_data_input};
    sel_sync <= {sel_sync[0], link.frame_sel_n};
    load_sync <= {load_sync[0], link.latch_load_n};
  end
  // Previous values for edge detection on synchronised pins.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      clk_prev <= 1'b0; // Link clock idles low, so no false fall after reset.
      sel_prev <= 1'b1;
      load_prev <= 1'b1;
    end else begin
      clk_prev <= clk_sync[1];
      sel_prev <= sel_sync[1];
      load_prev <= load_sync[1];
    end
  end
  logic clk_fall, sel_fall, load_fall;
  assign clk_fall = clk_prev & ~clk_sync[1];
  assign sel_fall = sel_prev & ~sel_sync[1];
  assign load_fall = load_prev & ~load_sync[1];
  // ==========================================================
  // Shift register and bit counter
  logic [`SDL_WORD_BITS-1:0] shift_reg;
  logic [`SDL_CNT_BITS-1:0] bit_cnt;
  logic word_done, accept;
  assign accept = clk_fall & ~sel_sync[1] & ~sel_fall & (bit_cnt != `SDL_CNT_FULL);
  assign word_done = (bit_cnt == `SDL_CNT_FULL);
  // Frame start clears the count; each accepted fall shifts one bit in, MSB first.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      bit_cnt <= '0;
      shift_reg <= '0;
    end else if (sel_fall) begin
      bit_cnt <= '0;
    end else if (accept) begin
      bit_cnt <= bit_cnt + `SDL_CNT_BITS'(1);
      shift_reg <= {shift_reg[`SDL_WORD_BITS-2:0], data_sync[1]};
    end
  end
  // ==========================================================
  // Mode selection and output latch
  logic auto_mode, pending;
  // Load level after select falls picks the update mode.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      auto_mode <= 1'b0;
    end else if (sel_fall) begin
      auto_mode <= ~load_sync[1];
    end
  end
  assign auto_mode_out = auto_mode;
  // A word waits for a load pulse in load-pulse mode.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      pending <= 1'b0;
    end else if (sel_fall) begin
      pending <= 1'b0;
    end else if (accept && bit_cnt == `SDL_CNT_FULL - `SDL_CNT_BITS'(1) && !auto_mode) begin
      pending <= 1'b1;
    end else if (load_fall && pending) begin
      pending <= 1'b0;
    end
  end
  logic [`SDL_WORD_BITS-1:0] next_word;
  logic auto_hit;
  assign next_word = {shift_reg[`SDL_WORD_BITS-2:0], data_sync[1]};
  assign auto_hit = accept && auto_mode && bit_cnt == `SDL_CNT_FULL - `SDL_CNT_BITS'(1);
  // Latch takes the low twelve bits; the first four are dropped.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      dac_value_out <= '0;
      dac_update_out <= 1'b0;
    end else begin
      dac_update_out <= 1'b0;
      if (auto_hit) begin
        dac_value_out <= next_word[`SDL_DATA_BITS-1:0];
        dac_update_out <= 1'b1;
      end else if (load_fall && pending && word_done) begin
        dac_value_out <= shift_reg[`SDL_DATA_BITS-1:0];
        dac_update_out <= 1'b1;
      end
    end
  end
endmodule // sdl_device

/* rtl/sdl_host.sv */
`timescale 1ns/1ps
`include "sdl_defs.svh"
// Host end: sends one 16-bit word in one unbroken run of 16 link clocks, MSB first, data valid at falling edges.
module sdl_host
  import sdl_pkg::*;
(
  input wire logic sys_clk_in, // System clock.
  input wire logic reset_in, // Synchronous reset, active high.
  sdl_link_if.host link, // Serial link to the device.
  input wire logic send_in, // Start pulse for a word.
  input wire logic [`SDL_DATA_BITS-1:0] value_in, // Value to send.
  input wire logic offset_bin_in, // Value is offset binary.
  input wire logic auto_in, // Use automatic update.
  output logic busy_out, // Transfer in progress.
  output logic done_out // One-cycle pulse at transfer end.
);
  sdl_host_state_t state;
  logic [`SDL_WORD_BITS-1:0] word;
  logic [`SDL_CNT_BITS-1:0] bits;
  logic [`SDL_DIV_BITS-1:0] div;
  logic auto_mode;
  // ==========================================================
  // Transfer sequencer and clock divider.
  always_ff @(posedge sys_clk_in) begin
    if (reset_in) begin
      state <= SDL_IDLE;
      link.shift_clk <= 1'b0; // idle low
      link.serial_data_input <= 1'b0;
      link.frame_sel_n <= 1'b1;
      link.latch_load_n <= 1'b1;
      word <= '0;
      bits <= '0;
      div <= '0;
      auto_mode <= 1'b0;
      busy_out <= 1'b0;
      done_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      case (state)
        SDL_IDLE: begin
          link.latch_load_n <= 1'b1;
          if (send_in) begin
            word <= {4'h0, value_in[`SDL_MSB_BIT] ^ offset_bin_in, value_in[`SDL_MSB_BIT-1:0]};
            auto_mode <= auto_in;
            link.latch_load_n <= ~auto_in;
            link.frame_sel_n <= 1'b0;
            bits <= '0;
            div <= '0;
            busy_out <= 1'b1;
            state <= SDL_SHIFT;
          end
        end
        SDL_SHIFT: begin
          div <= div + `SDL_DIV_BITS'(1);
          if (div == `SDL_HALF_DIV - `SDL_DIV_BITS'(1)) begin
            div <= '0;
            if (!link.shift_clk) begin
              // Rising edge: present next bit, stable through the fall.
              link.shift_clk <= 1'b1;
              link.serial_data_input <= word[`SDL_WORD_BITS-1];
              word <= {word[`SDL_WORD_BITS-2:0], 1'b0};
            end else begin
              link.shift_clk <= 1'b0;
              bits <= bits + `SDL_CNT_BITS'(1);
              if (bits == `SDL_CNT_FULL - `SDL_CNT_BITS'(1)) state <= SDL_END;
            end
          end
        end
        SDL_END: begin
          div <= div + `SDL_DIV_BITS'(1);
          if (div == `SDL_HALF_DIV - `SDL_DIV_BITS'(1)) begin
            div <= '0;
            link.frame_sel_n <= 1'b1;
            if (auto_mode) begin
              link.latch_load_n <= 1'b1;
              state <= SDL_GAP;
            end else begin
              link.latch_load_n <= 1'b0;
              state <= SDL_LOAD;
            end
          end
        end
        SDL_LOAD: begin
          div <= div + `SDL_DIV_BITS'(1);
          if (div == `SDL_LOAD_PULSE - `SDL_DIV_BITS'(1)) begin
            div <= '0;
            link.latch_load_n <= 1'b1;
            state <= SDL_GAP;
          end
        end
        SDL_GAP: begin
          div <= div + `SDL_DIV_BITS'(1);
          if (div == `SDL_HALF_DIV - `SDL_DIV_BITS'(1)) begin
            div <= '0;
            busy_out <= 1'b0;
            done_out <= 1'b1;
            state <= SDL_IDLE;
          end
        end
        default: state <= SDL_IDLE;
      endcase
    end
  end
endmodule // sdl_host
